/* File: cfep_core.sv */
// Purpose: four-phase fetch/execute sequencing of an 8-bit core
// Assumes: program and data memories answer within one clock
// Notes: one-level return register; no return stack, no banking
`timescale 1ns/1ps

// Functional notes
// - Clock divided into four phase cycle
// - PC advances phase one, fetch captured phase four
// - Fetch next while current executes, overlapped
// - Instruction register loads phase one, executes after
// - Operand read phase two, write phase four
// - PC-changing instructions flush, take two cycles; two-word jump/call take three
// - Byte addressed memory, words at even address
// - PC steps by two, LSB zero
// - Absolute jump/call word address into PC<20:1>
// - Relative branch offset counts words, doubled
// - Four two-word instructions supported
// - Second word tagged 1111, twelve literal bits
// - Lone second word executes as no-operation
// - Computed jump adds working register to low PC
// - Return with literal loads W, returns
// - Table transfer moves one byte via latch
module cfep_core
  import cfep_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 ce_i,
  input  wire logic [IW-1:0]        pm_data_i,
  input  wire logic [7:0]           dm_rdata_i,
  input  wire logic [7:0]           tbl_rdata_i,
  output logic      [PC_W-1:0]      pm_addr_o,
  output logic      [PC_W-1:0]      pc_o,
  output logic      [3:0]           phase_o,
  output logic      [7:0]           working_register_o,
  output logic      [2:0][DA_W-1:0] file_select_o,
  output cfep_dm_req_t              dm_req_o,
  output cfep_tbl_req_t             tbl_req_o
);
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] fetch_addr;
  logic [IW-1:0]   fetch_word;
  logic            fetch_valid;
  logic [IW-1:0]   ir;
  logic            ir_valid;
  logic [IW-1:0]   first_word;
  cfep_op_t        pend_op;
  logic            pending;
  logic [7:0]      working_register;
  logic [7:0]      operand;
  logic [PC_W-1:0] ret_addr;
  logic [PC_W-1:0] table_byte_pointer;
  logic [7:0]      table_data_latch;
  logic [2:0][DA_W-1:0] fsel;
  cfep_dm_req_t    dm_req;
  cfep_tbl_req_t   tbl_req;
  logic [3:0]      phase;
  cfep_dec_t       dec;

  cfep_phase_gen u_phase (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .ce_i     (ce_i),
    .phase_o  (phase)
  );

  // Qualified phase strobes, all frozen by the clock enable
  wire logic ph1 = ce_i && phase == PH_ONE;
  wire logic ph2 = ce_i && phase == PH_TWO;
  wire logic ph3 = ce_i && phase == PH_THREE;
  wire logic ph4 = ce_i && phase == PH_FOUR;

  // At phase one decode the word about to enter the register
  wire logic [IW-1:0] dec_word = (phase == PH_ONE) ? fetch_word : ir;
  wire logic live = (phase == PH_ONE) ? fetch_valid : ir_valid;

  cfep_decoder u_dec (
    .word_i (dec_word),
    .dec_o  (dec)
  );

  // Two-word pairing: a tagged word only acts right after its first
  wire logic is_second = live && dec.op == OP_SECOND && pending;
  wire logic first_half = live && (dec.op == OP_ABS_JUMP ||
                          dec.op == OP_CALL || dec.op == OP_FILE_MOVE ||
                          dec.op == OP_LOAD_FSEL);
  wire cfep_op_t act = !live ? OP_NOP :
                       is_second ? pend_op :
                       (dec.op == OP_SECOND) ? OP_NOP : dec.op;
  wire logic run_jump  = is_second && (act == OP_ABS_JUMP ||
                                       act == OP_CALL);
  wire logic run_fsel  = is_second && act == OP_LOAD_FSEL;
  wire logic run_fmove = is_second && act == OP_FILE_MOVE;

  // Data memory operand and destination selection
  wire logic need_rd = (act == OP_ADD_W_FILE || act == OP_TEST_SKIP ||
                       (act == OP_FILE_MOVE && !is_second));
  wire logic need_wr = (act == OP_ADD_W_FILE && dec.to_file) ||
                       act == OP_MOVE_W_FILE || run_fmove;
  wire logic [7:0] sum = operand + working_register;
  wire logic [7:0] wval = (act == OP_ADD_W_FILE) ? sum :
                          run_fmove ? operand : working_register;

  // Low PC and table latch files answer reads instead of the data memory
  wire logic [7:0] rd_val =
    (dm_req.addr == ADDR_PC_LOW) ? fetch_addr[7:0] :
    (dm_req.addr == ADDR_TLAT)   ? table_data_latch : dm_rdata_i;

  // Targets; fetch_addr already points past the executing word
  wire logic [PC_W-2:0] abs_word = {ir[11:0], first_word[7:0]};
  wire logic [PC_W-1:0] abs_tgt  = word_to_byte(abs_word);
  wire logic [PC_W-1:0] bra_tgt  = fetch_addr +
    word_to_byte({{9{ir[10]}}, ir[10:0]});
  wire logic pcl_wr = need_wr && dec.fa == ADDR_PC_LOW && !run_fmove;
  // Low PC bit is forced; an odd offset cannot misalign fetches
  wire logic [PC_W-1:0] pcl_tgt =
    {fetch_addr[PC_W-1:8], wval[7:1], 1'b0};
  wire logic skip = act == OP_TEST_SKIP && operand == 8'h00;
  wire logic jump = run_jump || act == OP_BRANCH ||
                    act == OP_RET_LIT || pcl_wr;
  wire logic [PC_W-1:0] next_pc =
    run_jump ? abs_tgt :
    (act == OP_BRANCH) ? bra_tgt :
    (act == OP_RET_LIT) ? ret_addr : pcl_tgt;
  wire logic [1:0] fsel_idx = first_word[5:4];

  // Program counter and fetch stage
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc          <= PC_RESET;
      fetch_addr  <= PC_RESET;
      fetch_word  <= '0;
      fetch_valid <= 1'b0;
    end else if (ph1) begin
      fetch_addr <= pc;
      pc         <= pc + PC_STEP;
    end else if (ph4) begin
      fetch_word  <= pm_data_i;
      fetch_valid <= !(jump || skip);
      if (jump) begin
        pc <= next_pc;
      end
    end
  end

  // Instruction register and two-word context
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ir         <= '0;
      ir_valid   <= 1'b0;
      first_word <= '0;
      pend_op    <= OP_NOP;
      pending    <= 1'b0;
    end else if (ph1) begin
      ir       <= fetch_word;
      ir_valid <= fetch_valid;
    end else if (ph4) begin
      pending <= first_half && !is_second;
      if (first_half) begin
        first_word <= ir;
        pend_op    <= dec.op;
      end
    end
  end

  // Data memory strobes; read owns phase two, write phase four
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dm_req  <= '0;
      operand <= '0;
    end else if (ph1) begin
      dm_req.rd   <= need_rd;
      dm_req.addr <= dec.fa;
    end else if (ph2) begin
      dm_req.rd <= 1'b0;
      if (dm_req.rd) begin
        operand <= rd_val;
      end
    end else if (ph3) begin
      dm_req.wr    <= need_wr;
      dm_req.addr  <= dec.fa;
      dm_req.wdata <= wval;
    end else if (ph4) begin
      dm_req.wr <= 1'b0;
    end
  end

  // Architectural registers commit at the end of phase four
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      working_register <= '0;
      ret_addr         <= PC_RESET;
      fsel             <= '0;
    end else if (ph4) begin
      if (act == OP_LOAD_W || act == OP_RET_LIT) begin
        working_register <= dec.lit;
      end else if (act == OP_ADD_W_FILE && !dec.to_file) begin
        working_register <= sum;
      end
      if (run_jump && act == OP_CALL) begin
        ret_addr <= fetch_addr;
      end
      if (run_fsel && fsel_idx < FSEL_COUNT) begin
        fsel[fsel_idx] <= {first_word[3:0], ir[7:0]};
      end
    end
  end

  // Table transfers: one byte between latch and program memory
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tbl_req            <= '0;
      table_byte_pointer <= PC_RESET;
      table_data_latch   <= '0;
    end else if (ph1) begin
      tbl_req.rd   <= live && dec.op == OP_TABLE_RD;
      tbl_req.addr <= table_byte_pointer;
    end else if (ph2) begin
      tbl_req.rd <= 1'b0;
      if (tbl_req.rd) begin
        table_data_latch <= tbl_rdata_i;
      end
    end else if (ph3) begin
      tbl_req.wr    <= act == OP_TABLE_WR;
      tbl_req.wdata <= table_data_latch;
    end else if (ph4) begin
      tbl_req.wr <= 1'b0;
      if (need_wr && !run_fmove) begin
        case (dec.fa)
          ADDR_TPTR_L: table_byte_pointer[7:0]   <= wval;
          ADDR_TPTR_H: table_byte_pointer[15:8]  <= wval;
          ADDR_TPTR_U: table_byte_pointer[20:16] <= wval[4:0];
          ADDR_TLAT:   table_data_latch          <= wval;
          default:     table_data_latch          <= table_data_latch;
        endcase
      end
    end
  end

  // Outputs come straight from state flops
  assign pm_addr_o          = fetch_addr;
  assign pc_o               = pc;
  assign phase_o            = phase;
  assign working_register_o = working_register;
  assign file_select_o      = fsel;
  assign dm_req_o           = dm_req;
  assign tbl_req_o          = tbl_req;

  a_pc_even_always: assert property (
    @(posedge clk_i) disable iff (!arst_n_i) pc[0] == 1'b0)
    else $error("program counter low bit set");

  a_pc_step_phase: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ph1 |=> pc == $past(pc) + PC_STEP && fetch_addr == $past(pc))
    else $error("program counter did not step at phase one");

  a_ir_load_phase: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ph1 |=> ir == $past(fetch_word) && ir_valid == $past(fetch_valid))
    else $error("instruction register not loaded at phase one");

  a_read_phase_two: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    dm_req.rd |-> phase == PH_TWO)
    else $error("operand read outside phase two");

  a_write_phase_four: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    dm_req.wr |-> phase == PH_FOUR)
    else $error("destination write outside phase four");

  a_flush_two_cycles: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ph4 && jump |=> !fetch_valid ##1 (!ce_i || !ir_valid))
    else $error("branch did not discard prefetched word");

  a_abs_jump_target: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ph4 && run_jump |=> pc == {$past(ir[11:0]), $past(first_word[7:0]),
                              1'b0})
    else $error("absolute target not placed in PC upper bits");

  a_lone_second_nop: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ph3 && live && dec.op == OP_SECOND && !pending |=>
      !dm_req.wr ##1 pc == $past(pc, 2) || !fetch_valid)
    else $error("standalone second word had an effect");

  a_flushed_slot_quiet: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ph3 && !ir_valid |=> !dm_req.wr && !tbl_req.wr)
    else $error("discarded slot wrote memory");

  a_return_literal: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ph4 && act == OP_RET_LIT |=>
      working_register == $past(dec.lit) && pc == $past(ret_addr))
    else $error("return with literal misbehaved");

  a_fetch_capture: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ph4 |=> fetch_word == $past(pm_data_i))
    else $error("fetch word not captured at phase four");

  a_plain_step: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ph4 && !jump && !skip |=> fetch_valid && pc == $past(pc))
    else $error("straight-line cycle lost its prefetched word");

  a_skip_discard: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ph4 && skip |=> !fetch_valid)
    else $error("skip did not discard the next word");

  a_branch_target: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ph4 && act == OP_BRANCH |=> pc == $past(fetch_addr) +
      {{9{$past(ir[10])}}, $past(ir[10:0]), 1'b0})
    else $error("relative branch offset not counted in words");

  a_pair_pending: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ph4 && first_half |=> pending && pend_op == $past(dec.op))
    else $error("first word of a pair not remembered");

  a_fsel_load: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ph4 && run_fsel && fsel_idx < FSEL_COUNT |=>
      fsel[$past(fsel_idx)] == {$past(first_word[3:0]), $past(ir[7:0])})
    else $error("select pointer not loaded from both words");

  a_low_pc_target: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ph4 && pcl_wr |=> pc[7:0] == {$past(wval[7:1]), 1'b0})
    else $error("computed jump target wrong or odd");

  a_table_rd_phase: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    tbl_req.rd |-> phase == PH_TWO)
    else $error("table read outside phase two");

  a_table_wr_phase: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    tbl_req.wr |-> phase == PH_FOUR && tbl_req.wdata == table_data_latch)
    else $error("table write outside phase four or not from latch");
endmodule

/* File: cfep_pkg.sv */
// Purpose: shared constants and types for the fetch/execute core
// Assumes: one core clock, four phases make one instruction cycle
// Notes: opcode field values pick the supported instruction subset
package cfep_pkg;
  localparam int PC_W = 21;
  localparam int DA_W = 12;
  localparam int IW   = 16;

  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP  = 21'h000002;

  // One-hot phase codes, rotated left once per clock
  localparam logic [3:0] PH_ONE   = 4'h1;
  localparam logic [3:0] PH_TWO   = 4'h2;
  localparam logic [3:0] PH_THREE = 4'h4;
  localparam logic [3:0] PH_FOUR  = 4'h8;

  // Internal file addresses served by the core itself
  localparam logic [DA_W-1:0] ADDR_PC_LOW = 12'hff9;
  localparam logic [DA_W-1:0] ADDR_TPTR_L = 12'hff6;
  localparam logic [DA_W-1:0] ADDR_TPTR_H = 12'hff7;
  localparam logic [DA_W-1:0] ADDR_TPTR_U = 12'hff8;
  localparam logic [DA_W-1:0] ADDR_TLAT   = 12'hff5;

  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] GPR_BANK     = 4'h0;
  localparam logic [3:0] SFR_BANK     = 4'hf;
  localparam logic [3:0] SECOND_TAG   = 4'hf;
  localparam logic [1:0] FSEL_COUNT   = 2'h3;

  // Opcode prefixes, compared against the top bits of a word
  localparam logic [5:0]  OPC_ADD_W_FILE  = 6'h09;
  localparam logic [6:0]  OPC_MOVE_W_FILE = 7'h37;
  localparam logic [6:0]  OPC_TEST_SKIP   = 7'h33;
  localparam logic [7:0]  OPC_LOAD_W      = 8'h0e;
  localparam logic [7:0]  OPC_RET_LIT     = 8'h0c;
  localparam logic [4:0]  OPC_BRANCH      = 5'h1a;
  localparam logic [7:0]  OPC_ABS_JUMP    = 8'hef;
  localparam logic [6:0]  OPC_CALL        = 7'h76;
  localparam logic [3:0]  OPC_FILE_MOVE   = 4'hc;
  localparam logic [9:0]  OPC_LOAD_FSEL   = 10'h3b8;
  localparam logic [15:0] OPC_TABLE_RD    = 16'h0008;
  localparam logic [15:0] OPC_TABLE_WR    = 16'h000c;

  typedef enum logic [3:0] {
    OP_NOP, OP_LOAD_W, OP_ADD_W_FILE, OP_MOVE_W_FILE, OP_TEST_SKIP,
    OP_RET_LIT, OP_BRANCH, OP_ABS_JUMP, OP_CALL, OP_FILE_MOVE,
    OP_LOAD_FSEL, OP_TABLE_RD, OP_TABLE_WR, OP_SECOND
  } cfep_op_t;

  typedef struct packed {
    cfep_op_t        op;
    logic [DA_W-1:0] fa;
    logic            to_file;
    logic [7:0]      lit;
  } cfep_dec_t;

  typedef struct packed {
    logic            rd;
    logic            wr;
    logic [DA_W-1:0] addr;
    logic [7:0]      wdata;
  } cfep_dm_req_t;

  typedef struct packed {
    logic            rd;
    logic            wr;
    logic [PC_W-1:0] addr;
    logic [7:0]      wdata;
  } cfep_tbl_req_t;

  // Word address to even byte address
  function automatic logic [PC_W-1:0] word_to_byte(
      input logic [PC_W-2:0] w);
    return {w, 1'b0};
  endfunction
endpackage

/* File: cfep_phase_gen.sv */
// Purpose: four-phase sequencer, one instruction cycle per rotation
// Assumes: clock enable freezes the rotation
// Notes: one-hot code, phase_o names the phase ending at next edge
`timescale 1ns/1ps
module cfep_phase_gen
  import cfep_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       ce_i,
  output logic      [3:0] phase_o
);
  // Rotate one-hot phase; reset starts a fresh cycle at phase one
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_o <= PH_ONE;
    end else if (ce_i) begin
      phase_o <= {phase_o[2:0], phase_o[3]};
    end
  end

  a_phase_onehot: assert property (
    @(posedge clk_i) disable iff (!arst_n_i) $onehot(phase_o))
    else $error("phase code not one-hot");

  a_phase_cycle_four: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && phase_o == PH_ONE) ##1 ce_i [*3] |=> phase_o == PH_ONE)
    else $error("instruction cycle is not four phases");
endmodule

/* File: cfep_decoder.sv */
// Purpose: instruction word decode for the supported subset
// Assumes: word is stable while the core samples the result
// Notes: any word with the second-word tag decodes as OP_SECOND
`timescale 1ns/1ps
module cfep_decoder
  import cfep_pkg::*;
(
  input  wire logic [IW-1:0] word_i,
  output cfep_dec_t          dec_o
);
  // Access bank: low half is data RAM, upper half the special files
  function automatic logic [DA_W-1:0] file_addr(input logic bsel,
                                                 input logic [7:0] f);
    return (!bsel && f >= ACCESS_SPLIT) ? {SFR_BANK, f} : {GPR_BANK, f};
  endfunction

  wire logic is_add   = word_i[15:10] == OPC_ADD_W_FILE;
  wire logic is_movwf = word_i[15:9] == OPC_MOVE_W_FILE;
  wire logic is_test  = word_i[15:9] == OPC_TEST_SKIP;
  wire logic is_ldw   = word_i[15:8] == OPC_LOAD_W;
  wire logic is_ret   = word_i[15:8] == OPC_RET_LIT;
  wire logic is_bra   = word_i[15:11] == OPC_BRANCH;
  wire logic is_jmp   = word_i[15:8] == OPC_ABS_JUMP;
  wire logic is_call  = word_i[15:9] == OPC_CALL;
  wire logic is_fmove = word_i[15:12] == OPC_FILE_MOVE;
  wire logic is_fsel  = word_i[15:6] == OPC_LOAD_FSEL;
  wire logic is_scnd  = word_i[15:12] == SECOND_TAG;

  // Priority chain; unknown words execute as no-operation
  wire cfep_op_t op =
    is_scnd  ? OP_SECOND      : is_fmove ? OP_FILE_MOVE :
    is_jmp   ? OP_ABS_JUMP    : is_call  ? OP_CALL      :
    is_fsel  ? OP_LOAD_FSEL   : is_bra   ? OP_BRANCH    :
    is_add   ? OP_ADD_W_FILE  : is_movwf ? OP_MOVE_W_FILE :
    is_test  ? OP_TEST_SKIP   : is_ldw   ? OP_LOAD_W    :
    is_ret   ? OP_RET_LIT     :
    (word_i == OPC_TABLE_RD) ? OP_TABLE_RD :
    (word_i == OPC_TABLE_WR) ? OP_TABLE_WR : OP_NOP;

  // File moves and second words carry a full 12-bit file address
  wire logic full_fa = is_fmove || is_scnd;

  assign dec_o.op      = op;
  assign dec_o.fa      = full_fa ? word_i[11:0]
                                 : file_addr(word_i[8], word_i[7:0]);
  assign dec_o.to_file = word_i[9];
  assign dec_o.lit     = word_i[7:0];
endmodule

/* File: cfep_mem_model.sv */
// Purpose: program, data and table memories facing the core
// Assumes: combinational reads, data writes on the phase-four edge
// Notes: idle read buses show inverted data to expose stale samples
`timescale 1ns/1ps
module cfep_mem_model
  import cfep_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            ce_i,
  input  wire logic [PC_W-1:0] pm_addr_i,
  input  wire cfep_dm_req_t    dm_req_i,
  input  wire cfep_tbl_req_t   tbl_req_i,
  output logic      [IW-1:0]   pm_data_o,
  output logic      [7:0]      dm_rdata_o,
  output logic      [7:0]      tbl_rdata_o
);
  logic [IW-1:0] pm [0:255];
  logic [7:0]    dm [0:4095];
  logic [7:0]    tbl_byte;
  logic [7:0]    dm_byte;
  logic [7:0]      tbl_wr_byte;
  logic [PC_W-1:0] tbl_wr_addr;

  // Word fetch, low byte sits at the even address
  assign pm_data_o = pm[pm_addr_i[8:1]];

  // Table bytes follow a fixed pattern of their address
  assign tbl_byte    = tbl_req_i.addr[7:0] ^ tbl_req_i.addr[15:8] ^ 8'h3c;
  assign tbl_rdata_o = tbl_req_i.rd ? tbl_byte : ~tbl_byte;

  // Reads only valid while the strobe is up
  assign dm_byte    = dm[dm_req_i.addr];
  assign dm_rdata_o = dm_req_i.rd ? dm_byte : ~dm_byte;

  // Destination write lands on the edge closing phase four
  always @(posedge clk_i) begin
    if (ce_i && dm_req_i.wr)
      dm[dm_req_i.addr] <= dm_req_i.wdata;
  end

  // Table writes only recorded; program words stay as loaded
  always @(posedge clk_i) begin
    if (ce_i && tbl_req_i.wr) begin
      tbl_wr_byte <= tbl_req_i.wdata;
      tbl_wr_addr <= tbl_req_i.addr;
    end
  end
endmodule

/* File: cfep_core_tb.sv */
// Purpose: self-checking bench for the fetch/execute core
// Assumes: short programs, each ending in a branch to itself
// Notes: results judged from data memory and the core outputs
`timescale 1ns/1ps
module cfep_core_tb
  import cfep_pkg::*;
();
  logic                 clk;
  logic                 arst_n;
  logic                 ce;
  logic [IW-1:0]        pm_data;
  logic [7:0]           dm_rdata;
  logic [7:0]           tbl_rdata;
  logic [PC_W-1:0]      pm_addr;
  logic [PC_W-1:0]      pc;
  logic [3:0]           phase;
  logic [7:0]           w_reg;
  logic [2:0][DA_W-1:0] fsel;
  cfep_dm_req_t         dm_req;
  cfep_tbl_req_t        tbl_req;
  int                   failures;
  int                   samples_checked;

  cfep_core u_cfep_core (
    .clk_i              (clk),
    .arst_n_i           (arst_n),
    .ce_i               (ce),
    .pm_data_i          (pm_data),
    .dm_rdata_i         (dm_rdata),
    .tbl_rdata_i        (tbl_rdata),
    .pm_addr_o          (pm_addr),
    .pc_o               (pc),
    .phase_o            (phase),
    .working_register_o (w_reg),
    .file_select_o      (fsel),
    .dm_req_o           (dm_req),
    .tbl_req_o          (tbl_req)
  );

  cfep_mem_model u_cfep_mem_model (
    .clk_i       (clk),
    .ce_i        (ce),
    .pm_addr_i   (pm_addr),
    .dm_req_i    (dm_req),
    .tbl_req_i   (tbl_req),
    .pm_data_o   (pm_data),
    .dm_rdata_o  (dm_rdata),
    .tbl_rdata_o (tbl_rdata)
  );

  // Free-running 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic steps(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  // Reset held while memories are reloaded
  task automatic start();
    arst_n = 1'b0;
    for (int i = 0; i < 256; i++)
      u_cfep_mem_model.pm[i] = 16'h0000;
    for (int i = 0; i < 4096; i++)
      u_cfep_mem_model.dm[i] = 8'h00;
  endtask

  task automatic release_rst();
    steps(16);
    arst_n = 1'b1;
  endtask

  task automatic prog(input logic [8:0] base, input logic [0:7][15:0] w);
    for (int i = 0; i < 8; i++)
      u_cfep_mem_model.pm[base[8:1] + i] = w[i];
  endtask

  // Phase rotation, counter stepping, freeze on clock enable
  task automatic t_phases();
    start();
    prog(9'h000, {16'h0000, 16'h0000, 16'hd7ff, {5{16'h0000}}});
    release_rst();
    chk("phase_rst", PH_ONE, phase);
    chk("pc_rst", PC_RESET, pc);
    steps(1);
    chk("phase_q2", PH_TWO, phase);
    chk("pc_q1", PC_STEP, pc);
    chk("pm_addr_q1", 0, pm_addr);
    steps(3);
    chk("phase_wrap", PH_ONE, phase);
    chk("pc_hold", PC_STEP, pc);
    ce = 1'b0;
    steps(3);
    chk("phase_frozen", PH_ONE, phase);
    ce = 1'b1;
    steps(1);
    chk("pc_next", 4, pc);
    chk("pm_addr_next", 2, pm_addr);
  endtask

  // Absolute jump with a flushed store right behind it
  task automatic t_jump();
    start();
    prog(9'h000, {16'h0e55, 16'hef08, 16'hf000, 16'h6e22, 16'h0eaa,
                  {3{16'h0000}}});
    prog(9'h010, {16'h6e20, 16'hd7ff, {6{16'h0000}}});
    release_rst();
    steps(80);
    chk("jump_store", 8'h55, u_cfep_mem_model.dm[12'h020]);
    chk("flushed_store", 8'h00, u_cfep_mem_model.dm[12'h022]);
    chk("jump_w", 8'h55, w_reg);
  endtask

  // Relative branch skipping two words
  task automatic t_branch();
    start();
    prog(9'h000, {16'hd002, 16'h0e11, 16'h0e22, 16'h0e33, 16'h6e21,
                  16'hd7ff, 16'h0000, 16'h0000});
    release_rst();
    steps(60);
    chk("branch_store", 8'h33, u_cfep_mem_model.dm[12'h021]);
    chk("branch_w", 8'h33, w_reg);
  endtask

  // Skip over a file move, then a select-pointer load
  task automatic t_two_word(input logic [7:0] val);
    start();
    u_cfep_mem_model.dm[12'h030] = val;
    u_cfep_mem_model.dm[12'h032] = 8'h5a;
    prog(9'h000, {16'h0e77, 16'h6630, 16'hc030, 16'hf032, 16'h6e31,
                  16'hee13, 16'hf0ab, 16'hd7ff});
    release_rst();
    steps(80);
    chk("move_dest", (val == 8'h00) ? 8'h5a : val,
        u_cfep_mem_model.dm[12'h032]);
    chk("after_second", 8'h77, u_cfep_mem_model.dm[12'h031]);
    chk("fsel_one", 12'h3ab, fsel[1]);
  endtask

  // Called table indexed through the low counter byte
  task automatic t_lookup(input logic [7:0] off, input logic [7:0] exp);
    start();
    prog(9'h000, {{8'h0e, off}, 16'hec80, 16'hf000, 16'h6e40, 16'hd7ff,
                  {3{16'h0000}}});
    prog(9'h100, {16'h26f9, 16'h0ca1, 16'h0cb2, 16'h0cc3, {4{16'h0000}}});
    release_rst();
    steps(100);
    chk("lookup_store", exp, u_cfep_mem_model.dm[12'h040]);
    chk("lookup_w", exp, w_reg);
  endtask

  // Table byte read through pointer and latch
  task automatic t_table();
    start();
    prog(9'h000, {16'h0e34, 16'h6ef6, 16'h0e12, 16'h6ef7, 16'h0e00,
                  16'h6ef8, 16'h0008, 16'h000c});
    prog(9'h010, {16'h24f5, 16'h6e50, 16'hd7ff, {5{16'h0000}}});
    release_rst();
    steps(100);
    chk("table_byte", 8'h1a, u_cfep_mem_model.dm[12'h050]);
    chk("ptr_low_write", 8'h34, u_cfep_mem_model.dm[12'hff6]);
    chk("table_wr_byte", 8'h1a, u_cfep_mem_model.tbl_wr_byte);
    chk("table_wr_addr", 21'h001234, u_cfep_mem_model.tbl_wr_addr);
  endtask

  // Strobe phases and address alignment on every edge
  always @(posedge clk) begin
    if (arst_n === 1'b1) begin
      if (dm_req.rd === 1'b1)
        chk("rd_phase", PH_TWO, phase);
      if (dm_req.wr === 1'b1)
        chk("wr_phase", PH_FOUR, phase);
      if (tbl_req.rd === 1'b1)
        chk("tbl_rd_phase", PH_TWO, phase);
      if (tbl_req.wr === 1'b1)
        chk("tbl_wr_phase", PH_FOUR, phase);
      chk("pc_lsb", 0, pc[0]);
      chk("pm_addr_lsb", 0, pm_addr[0]);
    end
  end

  // Guard against a hang, well past the expected run
  initial begin
    #1000000;
    failures++;
    finish_test();
  end

  initial begin
    failures = 0;
    samples_checked = 0;
    arst_n = 1'b0;
    ce = 1'b1;
    #5;
    t_phases();
    t_jump();
    t_branch();
    t_two_word(8'h00);
    t_two_word(8'h09);
    t_lookup(8'h00, 8'ha1);
    t_lookup(8'h02, 8'hb2);
    t_lookup(8'h04, 8'hc3);
    t_table();
    finish_test();
  end
endmodule
